// *** rtl/dma_irq_select.sv ***
// DMA interrupt cause, enable and endpoint select registers
// Summary of operation
// [RQ1] Cause bits refresh when a command completes
// [RQ2] Writing one clears a cause bit
// [RQ3] Host reads cause and masks with enable
// [RQ4] Bit 12 set on halt command
// [RQ5] Bit 10 set on internal end
// [RQ6] Bit 8 set when counter reaches zero
// [RQ7] Short packet early: internal end only
// [RQ8] Short packet at zero: both bits
// [RQ9] Zero without short packet: done only
// [RQ10] Enable bit gates matching cause bit
// [RQ11] Enables clear on power and bus reset
// [RQ12] Bits 3..1 select the endpoint FIFO
// [RQ13] Bit 0 selects transfer direction
// [RQ14] Software keeps selection off indexed endpoint
// [RQ15] Park selection on unused endpoint idle
// [RQ16] Software writes reserved bits as reset
// [RQ17] Summary bit cleared with cause and itself
// [RQ18] Summary high while enabled cause pending
`default_nettype none
module dma_irq_select
	import dma_irq_pkg::*;
(
	input  wire logic                         clock,
	input  wire logic                         rst,
	input  wire logic                         bus_reset,
	input  wire logic [dma_irq_pkg::ADDR_W-1:0] reg_addr,
	input  wire logic [dma_irq_pkg::DATA_W-1:0] reg_wdata,
	input  wire logic                         reg_write,
	input  wire logic                         reg_read,
	output logic      [dma_irq_pkg::DATA_W-1:0] reg_rdata,
	input  wire logic                         cmd_done,
	input  wire logic                         halt_cmd,
	input  wire logic                         short_packet,
	input  wire logic                         count_zero,
	output logic      [2:0]                   dma_ep_select,
	output logic                              fifo_direction,
	output logic                              device_irq_status,
	output logic                              irq
);
	import dma_irq_pkg::*;

	logic [15:0] enable_q;
	logic [15:0] enable_d;
	logic [7:0]  ep_sel_q;
	logic [7:0]  ep_sel_d;
	logic        summary_q;
	logic        summary_d;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;
	logic [15:0] cause;
	logic        hard_reset;

	// Decode
	wire sel_cause   = reg_addr == OFF_CAUSE;
	wire sel_enable  = reg_addr == OFF_ENABLE;
	wire sel_ep      = reg_addr == OFF_EP_SEL;
	wire sel_summary = reg_addr == OFF_SUMMARY;
	wire wr_cause    = reg_write & sel_cause;
	wire wr_enable   = reg_write & sel_enable;
	wire wr_ep       = reg_write & sel_ep;
	wire wr_summary  = reg_write & sel_summary;

	// [RQ11] Both resets clear
	assign hard_reset = rst | bus_reset;

	// [RQ1] Events on command completion
	wire ev_end  = cmd_done & (short_packet | count_zero);
	// [RQ7] [RQ8] Short packet sets internal end
	wire set_int_end = ev_end & short_packet;
	// [RQ6] [RQ9] Zero count sets done
	wire set_done    = ev_end & count_zero;
	// [RQ4] Halt command
	wire set_halt    = halt_cmd;

	wire [NUM_EVENTS-1:0] ev_set;
	wire [NUM_EVENTS-1:0] ev_clr;
	wire [NUM_EVENTS-1:0] ev_q;
	assign ev_set = {set_halt, set_int_end, set_done};
	// [RQ2] Write one clears
	assign ev_clr = {3{wr_cause}} & {reg_wdata[BIT_HALT],
		reg_wdata[BIT_INT_END], reg_wdata[BIT_DONE]};

	genvar gi;
	generate
		for (gi = 0; gi < NUM_EVENTS; gi++) begin : g_flag
			w1c_flag u_flag (
				.clock  (clock),
				.rst    (hard_reset),
				.set    (ev_set[gi]),
				.clr    (ev_clr[gi]),
				.flag_q (ev_q[gi])
			);
		end
	endgenerate

	// [RQ5] Place flags at cause positions
	always_comb begin
		cause = CAUSE_RESET;
		cause[BIT_HALT] = ev_q[2];
		cause[BIT_INT_END] = ev_q[1];
		cause[BIT_DONE] = ev_q[0];
	end

	// [RQ10] Enable gates each cause
	wire [15:0] pending = cause & enable_q & CAUSE_MASK;
	wire        any_pending = |pending;

	assign enable_d = wr_enable ? reg_wdata[15:0] : enable_q;
	assign ep_sel_d = wr_ep ? reg_wdata[7:0] : ep_sel_q;

	// [RQ17] Summary sticky, cleared by writing one
	assign summary_d = any_pending |
		(summary_q & ~(wr_summary & reg_wdata[SUMMARY_BIT]));

	wire [31:0] rd_mux =
		sel_cause   ? {16'h0000, cause} :
		sel_enable  ? {16'h0000, enable_q} :
		sel_ep      ? {24'h000000, ep_sel_q} :
		sel_summary ? {31'h00000000, summary_q} : 32'h00000000;
	assign rdata_d = reg_read ? rd_mux : 32'h00000000;

	always_ff @(posedge clock) begin
		if (hard_reset) begin
			enable_q  <= ENABLE_RESET;
			ep_sel_q  <= EP_SEL_RESET;
			summary_q <= 1'b0;
		end else begin
			enable_q  <= enable_d;
			ep_sel_q  <= ep_sel_d;
			summary_q <= summary_d;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			rdata_q <= 32'h00000000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	// [RQ12] Endpoint index
	assign dma_ep_select = ep_sel_q[EP_MSB:EP_LSB];
	// [RQ13] Direction
	assign fifo_direction = ep_sel_q[DIR_BIT];
	assign device_irq_status = summary_q;
	// [RQ18] Level interrupt
	assign irq = summary_q;

	// [RQ4] Halt sets flag
	AST_HALT_SET: assert property ( // [RQ4]
		@(posedge clock) disable iff (hard_reset)
		halt_cmd |=> cause[BIT_HALT]
	) else $error("halt flag not set");

	// [RQ5] Internal end sets
	AST_INT_END: assert property ( // [RQ5]
		@(posedge clock) disable iff (hard_reset)
		cmd_done && short_packet |=> cause[BIT_INT_END]
	) else $error("internal end not set");

	// [RQ6] Zero count sets
	AST_DONE: assert property ( // [RQ6]
		@(posedge clock) disable iff (hard_reset)
		cmd_done && count_zero |=> cause[BIT_DONE]
	) else $error("done not set");

	// [RQ7] Early short packet
	AST_NO_DONE: assert property ( // [RQ7]
		@(posedge clock) disable iff (hard_reset)
		cmd_done && short_packet && !count_zero && !cause[BIT_DONE]
		&& !wr_cause |=> !cause[BIT_DONE]
	) else $error("done set early");

	// [RQ8] Short packet at zero
	AST_BOTH: assert property ( // [RQ8]
		@(posedge clock) disable iff (hard_reset)
		cmd_done && short_packet && count_zero
		|=> cause[BIT_DONE] && cause[BIT_INT_END]
	) else $error("both not set");

	// [RQ9] Zero without short packet
	AST_NO_INT: assert property ( // [RQ9]
		@(posedge clock) disable iff (hard_reset)
		cmd_done && !short_packet && !cause[BIT_INT_END]
		|=> !cause[BIT_INT_END]
	) else $error("internal end spurious");

	// [RQ2] Done clears
	AST_W1C: assert property ( // [RQ2]
		@(posedge clock) disable iff (hard_reset)
		wr_cause && reg_wdata[BIT_DONE] && !(cmd_done && count_zero)
		|=> !cause[BIT_DONE]
	) else $error("clear failed");

	// [RQ2] Halt clears
	AST_W1C_HALT: assert property ( // [RQ2]
		@(posedge clock) disable iff (hard_reset)
		wr_cause && reg_wdata[BIT_HALT] && !halt_cmd
		|=> !cause[BIT_HALT]
	) else $error("halt clear failed");

	// [RQ2] Internal end clears
	AST_W1C_INT: assert property ( // [RQ2]
		@(posedge clock) disable iff (hard_reset)
		wr_cause && reg_wdata[BIT_INT_END] && !(cmd_done && short_packet)
		|=> !cause[BIT_INT_END]
	) else $error("internal end clear failed");

	// [RQ2] Zero keeps done
	AST_W0_DONE: assert property ( // [RQ2]
		@(posedge clock) disable iff (hard_reset)
		wr_cause && !reg_wdata[BIT_DONE] && cause[BIT_DONE]
		|=> cause[BIT_DONE]
	) else $error("done lost on zero write");

	// [RQ2] Zero keeps halt
	AST_W0_HALT: assert property ( // [RQ2]
		@(posedge clock) disable iff (hard_reset)
		wr_cause && !reg_wdata[BIT_HALT] && cause[BIT_HALT]
		|=> cause[BIT_HALT]
	) else $error("halt lost on zero write");

	// [RQ2] Zero keeps internal end
	AST_W0_INT: assert property ( // [RQ2]
		@(posedge clock) disable iff (hard_reset)
		wr_cause && !reg_wdata[BIT_INT_END] && cause[BIT_INT_END]
		|=> cause[BIT_INT_END]
	) else $error("internal end lost on zero write");

	// [RQ1] No done outside command
	AST_IDLE_DONE: assert property ( // [RQ1]
		@(posedge clock) disable iff (hard_reset)
		!cmd_done && !cause[BIT_DONE] |=> !cause[BIT_DONE]
	) else $error("done without command");

	// [RQ1] No end outside command
	AST_IDLE_INT: assert property ( // [RQ1]
		@(posedge clock) disable iff (hard_reset)
		!cmd_done && !cause[BIT_INT_END] |=> !cause[BIT_INT_END]
	) else $error("internal end without command");

	// [RQ4] No halt without command
	AST_IDLE_HALT: assert property ( // [RQ4]
		@(posedge clock) disable iff (hard_reset)
		!halt_cmd && !cause[BIT_HALT] |=> !cause[BIT_HALT]
	) else $error("halt without command");

	// [RQ10] Pending raises summary
	AST_GATE: assert property ( // [RQ10]
		@(posedge clock) disable iff (hard_reset)
		any_pending |=> summary_q
	) else $error("irq missing");

	// [RQ10] Masked cause stays quiet
	AST_MASKED: assert property ( // [RQ10]
		@(posedge clock) disable iff (hard_reset)
		!summary_q && !any_pending |=> !irq
	) else $error("irq while masked");

	// [RQ10] Enable readback
	AST_RD_ENABLE: assert property ( // [RQ10]
		@(posedge clock) disable iff (hard_reset)
		reg_read && sel_enable |=> reg_rdata[15:0] == $past(enable_q)
	) else $error("enable readback wrong");

	// [RQ11] Bus reset clears enable
	AST_RESET: assert property ( // [RQ11]
		@(posedge clock)
		$past(bus_reset) |-> enable_q == 16'h0000
	) else $error("enable not reset");

	// [RQ11] Power reset clears
	AST_ENABLE_RST: assert property ( // [RQ11]
		@(posedge clock)
		rst |=> enable_q == ENABLE_RESET && ep_sel_q == EP_SEL_RESET
	) else $error("power reset incomplete");

	// [RQ11] Bus reset clears select
	AST_EP_RST: assert property ( // [RQ11]
		@(posedge clock)
		bus_reset |=> dma_ep_select == 3'h0 && !fifo_direction
	) else $error("select not reset");

	// [RQ11] Resets clear causes
	AST_CAUSE_RST: assert property ( // [RQ11]
		@(posedge clock)
		hard_reset |=> cause == CAUSE_RESET
	) else $error("cause not reset");

	// [RQ12] Endpoint taken
	AST_EP: assert property ( // [RQ12]
		@(posedge clock) disable iff (hard_reset)
		wr_ep |=> dma_ep_select == $past(reg_wdata[3:1])
	) else $error("endpoint not taken");

	// [RQ12] Endpoint holds
	AST_EP_HOLD: assert property ( // [RQ12]
		@(posedge clock) disable iff (hard_reset)
		!wr_ep |=> $stable(ep_sel_q)
	) else $error("endpoint changed unwritten");

	// [RQ12] Select readback
	AST_RD_EP: assert property ( // [RQ12]
		@(posedge clock) disable iff (hard_reset)
		reg_read && sel_ep |=> reg_rdata[7:0] == $past(ep_sel_q)
	) else $error("select readback wrong");

	// [RQ13] Direction taken
	AST_DIR: assert property ( // [RQ13]
		@(posedge clock) disable iff (hard_reset)
		wr_ep |=> fifo_direction == $past(reg_wdata[0])
	) else $error("direction not taken");

	// [RQ3] Cause readback
	AST_RD_CAUSE: assert property ( // [RQ3]
		@(posedge clock) disable iff (hard_reset)
		reg_read && sel_cause |=> reg_rdata == {16'h0000, $past(cause)}
	) else $error("cause readback wrong");

	// [RQ3] Idle read data zero
	AST_RD_ZERO: assert property ( // [RQ3]
		@(posedge clock) disable iff (hard_reset)
		!reg_read |=> reg_rdata == 32'h00000000
	) else $error("read data without read");

	// [RQ17] Summary clears
	AST_SUM: assert property ( // [RQ17]
		@(posedge clock) disable iff (hard_reset)
		!any_pending && wr_summary && reg_wdata[SUMMARY_BIT] |=> !irq
	) else $error("summary not cleared");

	// [RQ17] Summary sticky
	AST_SUM_HOLD: assert property ( // [RQ17]
		@(posedge clock) disable iff (hard_reset)
		summary_q && !(wr_summary && reg_wdata[SUMMARY_BIT]) |=> summary_q
	) else $error("summary dropped");

	// [RQ17] Resets clear summary
	AST_SUM_RST: assert property ( // [RQ17]
		@(posedge clock)
		hard_reset |=> !summary_q
	) else $error("summary not reset");

	// [RQ18] Rise needs pending pair
	AST_IRQ_RISE: assert property ( // [RQ18]
		@(posedge clock) disable iff (hard_reset)
		$rose(summary_q) |-> $past(any_pending)
	) else $error("irq without cause");

	// [RQ18] Pending pair keeps irq
	AST_SUM_PEND: assert property ( // [RQ18]
		@(posedge clock) disable iff (hard_reset)
		any_pending && wr_summary && reg_wdata[SUMMARY_BIT] |=> irq
	) else $error("irq dropped while pending");
endmodule
`default_nettype wire

// *** rtl/dma_irq_pkg.sv ***
// Constants for the DMA interrupt and endpoint select block
`default_nettype none
package dma_irq_pkg;
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam logic [11:0] OFF_CAUSE = 12'h250;
	localparam logic [11:0] OFF_ENABLE = 12'h254;
	localparam logic [11:0] OFF_EP_SEL = 12'h258;
	localparam logic [11:0] OFF_SUMMARY = 12'h25C;
	localparam int unsigned BIT_HALT = 12;
	localparam int unsigned BIT_INT_END = 10;
	localparam int unsigned BIT_DONE = 8;
	localparam logic [15:0] CAUSE_MASK = 16'h1500;
	localparam logic [15:0] CAUSE_RESET = 16'h0000;
	localparam logic [15:0] ENABLE_RESET = 16'h0000;
	localparam logic [7:0] EP_SEL_RESET = 8'h00;
	localparam int unsigned EP_LSB = 1;
	localparam int unsigned EP_MSB = 3;
	localparam int unsigned DIR_BIT = 0;
	localparam int unsigned SUMMARY_BIT = 0;
	localparam int unsigned NUM_EVENTS = 3;
endpackage
`default_nettype wire

// *** rtl/w1c_flag.sv ***
// One sticky flag set by hardware, cleared by writing one
`default_nettype none
module w1c_flag (
	input  wire logic clock,
	input  wire logic rst,
	input  wire logic set,
	input  wire logic clr,
	output logic      flag_q
);
	logic flag_d;

	// Set wins over a clear in the same cycle
	assign flag_d = set | (flag_q & ~clr);

	always_ff @(posedge clock) begin
		if (rst) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end
endmodule
`default_nettype wire

// *** verification/dma_event_model.sv ***
// Event source standing in for the DMA engine
`default_nettype none
module dma_event_model (
	input  wire logic clock,
	output logic      cmd_done,
	output logic      halt_cmd,
	output logic      short_packet,
	output logic      count_zero
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{cmd_done, halt_cmd, short_packet, count_zero} = 4'h0;
	end
	task automatic fire(input logic h, input logic sp, input logic cz);
		@(posedge clock);
		halt_cmd <= h;
		cmd_done <= !h;
		short_packet <= sp;
		count_zero <= cz;
		@(posedge clock);
		{cmd_done, halt_cmd} <= 2'h0;
		short_packet <= !sp;
		count_zero <= !cz;
	endtask
endmodule
`default_nettype wire

// *** verification/usb_device_dma_irq_and_endpoint_select_test.sv ***
// Self-checking bench for DMA interrupt and endpoint select
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin \
	errors++; $display("Error %s expected %h seen %h", n, e, s); end end
module usb_device_dma_irq_and_endpoint_select_test import dma_irq_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic              clock = 1'b0, rst = 1'b1, bus_reset = 1'b0, rv;
	logic              reg_write = 1'b0, reg_read = 1'b0;
	logic [ADDR_W-1:0] reg_addr = 12'h000;
	logic [DATA_W-1:0] reg_wdata = 32'h0, reg_rdata, e, v, x = 32'h53;
	logic              cmd_done, halt_cmd, short_packet, count_zero;
	logic [2:0]        dma_ep_select;
	logic              fifo_direction, device_irq_status, irq;
	logic [31:0]       q[$];
	logic [31:0]       exp_c[4] = '{32'h400, 32'h500, 32'h100, 32'h1000};
	int                errors = 0, comparisons = 0;
	always #2 clock = ~clock;
	dma_irq_select u_dut (.clock(clock), .rst(rst), .bus_reset(bus_reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .cmd_done(cmd_done),
		.halt_cmd(halt_cmd), .short_packet(short_packet),
		.count_zero(count_zero), .dma_ep_select(dma_ep_select),
		.fifo_direction(fifo_direction),
		.device_irq_status(device_irq_status), .irq(irq));
	dma_event_model u_eng (.clock(clock), .cmd_done(cmd_done),
		.halt_cmd(halt_cmd), .short_packet(short_packet),
		.count_zero(count_zero));
	function automatic logic [31:0] rnd();
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] d);
		q.push_back(d);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
	endtask
	always @(posedge clock) rv <= reg_read;
	always @(negedge clock) if (rv === 1'b1) begin
		e = q.pop_front();
		`CHK("reg_rdata", e, reg_rdata)
	end
	task automatic report_and_stop();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge clock);
		errors++;
		report_and_stop();
	end
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		rd(OFF_CAUSE, 32'h0);
		rd(OFF_ENABLE, 32'h0);
		rd(12'h260, 32'h0);
		v = rnd() & 32'hF;
		wr(OFF_EP_SEL, v);
		rd(OFF_EP_SEL, v);
		@(negedge clock);
		`CHK("dma_ep_select", v[3:1], dma_ep_select)
		`CHK("fifo_direction", v[0], fifo_direction)
		for (int k = 0; k < 4; k++) begin
			v = rnd() & 32'h1500 & ~exp_c[k];
			wr(OFF_ENABLE, v);
			u_eng.fire(k == 3, k < 2, k > 0);
			// Host reads cause to find source
			rd(OFF_CAUSE, exp_c[k]);
			@(negedge clock);
			`CHK("irq masked", 1'b0, irq)
			wr(OFF_ENABLE, 32'h1500);
			rd(OFF_ENABLE, 32'h1500);
			@(negedge clock);
			`CHK("irq", 1'b1, irq)
			`CHK("summary", 1'b1, device_irq_status)
			wr(OFF_CAUSE, 32'h0);
			rd(OFF_CAUSE, exp_c[k]);
			wr(OFF_CAUSE, exp_c[k]);
			wr(OFF_SUMMARY, 32'h1);
			rd(OFF_CAUSE, 32'h0);
			@(negedge clock);
			`CHK("irq cleared", 1'b0, irq)
		end
		wr(OFF_EP_SEL, 32'hE);
		u_eng.fire(1'b0, 1'b1, 1'b1);
		rd(OFF_CAUSE, 32'h500);
		@(negedge clock);
		`CHK("irq before bus reset", 1'b1, irq)
		@(posedge clock);
		bus_reset <= 1'b1;
		@(posedge clock);
		bus_reset <= 1'b0;
		rd(OFF_ENABLE, 32'h0);
		rd(OFF_EP_SEL, 32'h0);
		rd(OFF_CAUSE, 32'h0);
		@(negedge clock);
		`CHK("irq after bus reset", 1'b0, irq)
		`CHK("select after bus reset", 3'h0, dma_ep_select)
		report_and_stop();
	end
endmodule
`default_nettype wire
